// [src/dcm_pkg.sv]
package dcm_pkg;

   // -----------------------------------------------------------------
   // widths
   // -----------------------------------------------------------------
   localparam int DCM_AW = 16;
   localparam int DCM_DW = 16;
   localparam int DCM_RW = 4;

   // -----------------------------------------------------------------
   // register byte offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] DCM_OFS_CTRL = 8'h00;
   localparam logic [7:0] DCM_OFS_ADDR_A = 8'h04;
   localparam logic [7:0] DCM_OFS_ADDR_B = 8'h08;
   localparam logic [7:0] DCM_OFS_DATA_A = 8'h0c;
   localparam logic [7:0] DCM_OFS_STATUS = 8'h10;
   localparam logic [7:0] DCM_OFS_CLEAR = 8'h14;
   localparam logic [7:0] DCM_OFS_IRQ_EN = 8'h18;

   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int DCM_CTRL_A_LSB = 0;
   localparam int DCM_CTRL_B_LSB = 8;
   localparam int DCM_CFG_W = 5;
   localparam int DCM_DATA_MH_LSB = 24;
   localparam int DCM_DATA_ML_LSB = 16;
   localparam int DCM_DATA_CH_LSB = 8;
   localparam int DCM_DATA_CL_LSB = 0;
   localparam int DCM_ST_A_BIT = 0;
   localparam int DCM_ST_B_BIT = 1;
   localparam int DCM_ST_W = 2;

   // -----------------------------------------------------------------
   // reset values
   // -----------------------------------------------------------------
   localparam logic [DCM_AW-1:0] DCM_ADDR_RST = 16'h0000;
   localparam logic [7:0] DCM_BYTE_RST = 8'h00;
   localparam logic [DCM_ST_W-1:0] DCM_ST_RST = 2'h0;
   localparam logic [31:0] DCM_WORD_ZERO = 32'h0000_0000;

   // -----------------------------------------------------------------
   // ahb-lite codes
   // -----------------------------------------------------------------
   localparam logic [1:0] DCM_HTRANS_NONSEQ = 2'h2;
   localparam logic DCM_HRESP_OKAY = 1'b0;

   // comparator qualification, one per comparator
   typedef struct packed {
      logic size_select;              // 1 = byte, 0 = word
      logic size_qualify_enable;
      logic rw_select;                // 1 = read, 0 = write
      logic direction_qualify_enable;
      logic enable;
   } dcm_cfg_t;

   // one observed cpu bus access
   typedef struct packed {
      logic valid;                    // one cycle per access
      logic [DCM_AW-1:0] addr;
      logic [DCM_DW-1:0] data;        // [15:8] byte at addr
      logic is_byte;                  // 1 = byte, 0 = word
      logic is_read;
   } dcm_access_t;

   // data compare of comparator a
   typedef struct packed {
      logic [7:0] data_mask_high;
      logic [7:0] data_mask_low;
      logic [7:0] data_compare_high;
      logic [7:0] data_compare_low;
   } dcm_data_t;

endpackage : dcm_pkg

// [src/dcm_top.sv]
`timescale 1ns/10ps

// Operation
// R1 - B without size qualify matches byte and word accesses at its address
// R2 - size qualify with byte select clear: only word accesses match
// R3 - size qualify with byte select set: only byte accesses match
// R4 - word access at address minus one never matches
// R5 - byte-qualified comparator ignores a word covering that address
// R6 - software loads the exact access address; no widening done
// R7 - direction qualify off: reads and writes both match
// R8 - A and B optionally qualify match by read or write
// R9 - A compares address, direction, size and data as configured
// R10 - word: lower-address byte vs high compare, next byte vs low
// R11 - both mask bytes zero: no data comparison for A
// R12 - unqualified size, full mask: word needs both bytes equal
// R13 - word-only with low mask: check only the next-address byte
// R14 - word-only with high mask: check only the programmed-address byte
// R15 - word-only with full mask: both bytes must equal compare
// R16 - byte-only with high mask: byte data vs high compare
// R17 - mask bit one compares its data bit; zero is don't-care
// R18 - match indication is a one-cycle pulse per qualifying access
module dcm_top
   import dcm_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire dcm_access_t cpu_access,
   output logic match_a,
   output logic match_b,
   output logic irq
);

   // -----------------------------------------------------------------
   // comparison functions
   // -----------------------------------------------------------------

   // address, size and direction qualification shared by A and B
   function automatic logic qual_hit(
      input dcm_cfg_t cfg,
      input dcm_access_t acc,
      input logic [DCM_AW-1:0] cmp_addr
   );
      logic hit;
      hit = cfg.enable && acc.valid;
      // exact address only, so a word at n-1 never hits n
      hit = hit && (acc.addr == cmp_addr); // R4 R5 R6
      if (cfg.size_qualify_enable) begin
         hit = hit && (acc.is_byte == cfg.size_select); // R1 R2 R3 R5
      end
      if (cfg.direction_qualify_enable) begin
         hit = hit && (acc.is_read == cfg.rw_select); // R7 R8
      end
      return hit;
   endfunction : qual_hit

   // masked data compare; byte access carries its byte in [15:8]
   function automatic logic data_hit(
      input dcm_data_t d,
      input logic [DCM_DW-1:0] bus
   );
      logic [DCM_DW-1:0] mask;
      logic [DCM_DW-1:0] cmp;
      mask = {d.data_mask_high, d.data_mask_low};
      cmp = {d.data_compare_high, d.data_compare_low}; // R10
      // all-zero mask yields a hit on any data
      return ((bus ^ cmp) & mask) == 16'h0000; // R11 R12 R13 R14 R15 R16 R17
   endfunction : data_hit

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   dcm_cfg_t cfg_a_reg, cfg_a_next;
   dcm_cfg_t cfg_b_reg, cfg_b_next;
   logic [DCM_AW-1:0] addr_a_reg, addr_a_next;
   logic [DCM_AW-1:0] addr_b_reg, addr_b_next;
   dcm_data_t data_a_reg, data_a_next;
   logic [DCM_ST_W-1:0] status_reg, status_next;
   logic [DCM_ST_W-1:0] irq_en_reg, irq_en_next;
   logic wr_pend_reg, wr_pend_next;
   logic [7:0] wr_ofs_reg, wr_ofs_next;
   logic [31:0] hrdata_reg, hrdata_next;
   logic match_a_reg, match_a_next;
   logic match_b_reg, match_b_next;
   logic irq_reg, irq_next;

   logic addr_phase;
   logic [7:0] ofs;
   logic [31:0] rd_word;
   logic [DCM_ST_W-1:0] clr_bits;
   logic [31:0] ctrl_word;

   // -----------------------------------------------------------------
   // bus slave
   // -----------------------------------------------------------------
   assign addr_phase = hsel && hready && (htrans == DCM_HTRANS_NONSEQ);
   assign ofs = haddr[7:0];

   always_comb begin
      ctrl_word = DCM_WORD_ZERO;
      ctrl_word[DCM_CTRL_A_LSB +: DCM_CFG_W] = cfg_a_reg;
      ctrl_word[DCM_CTRL_B_LSB +: DCM_CFG_W] = cfg_b_reg;
   end

   // read data chosen in the address phase, presented in the data phase
   always_comb begin
      rd_word = DCM_WORD_ZERO;
      case (ofs)
         DCM_OFS_CTRL: begin
            rd_word = ctrl_word;
         end
         DCM_OFS_ADDR_A: begin
            rd_word[DCM_AW-1:0] = addr_a_reg;
         end
         DCM_OFS_ADDR_B: begin
            rd_word[DCM_AW-1:0] = addr_b_reg;
         end
         DCM_OFS_DATA_A: begin
            rd_word = data_a_reg;
         end
         DCM_OFS_STATUS: begin
            rd_word[DCM_ST_W-1:0] = status_reg;
         end
         DCM_OFS_IRQ_EN: begin
            rd_word[DCM_ST_W-1:0] = irq_en_reg;
         end
         default: begin
            rd_word = DCM_WORD_ZERO;
         end
      endcase
   end

   always_comb begin
      wr_pend_next = addr_phase && hwrite;
      wr_ofs_next = addr_phase ? ofs : wr_ofs_reg;
      hrdata_next = (addr_phase && !hwrite) ? rd_word : DCM_WORD_ZERO;
      cfg_a_next = cfg_a_reg;
      cfg_b_next = cfg_b_reg;
      addr_a_next = addr_a_reg;
      addr_b_next = addr_b_reg;
      data_a_next = data_a_reg;
      irq_en_next = irq_en_reg;
      clr_bits = DCM_ST_RST;
      if (wr_pend_reg) begin
         case (wr_ofs_reg)
            DCM_OFS_CTRL: begin
               cfg_a_next = hwdata[DCM_CTRL_A_LSB +: DCM_CFG_W];
               cfg_b_next = hwdata[DCM_CTRL_B_LSB +: DCM_CFG_W];
            end
            DCM_OFS_ADDR_A: begin
               addr_a_next = hwdata[DCM_AW-1:0];
            end
            DCM_OFS_ADDR_B: begin
               addr_b_next = hwdata[DCM_AW-1:0];
            end
            DCM_OFS_DATA_A: begin
               data_a_next = hwdata;
            end
            DCM_OFS_CLEAR: begin
               clr_bits = hwdata[DCM_ST_W-1:0];
            end
            DCM_OFS_IRQ_EN: begin
               irq_en_next = hwdata[DCM_ST_W-1:0];
            end
            default: begin
               clr_bits = DCM_ST_RST;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // match and interrupt
   // -----------------------------------------------------------------
   always_comb begin
      // one pulse per valid access, so downstream sees one event each
      match_a_next = qual_hit(cfg_a_reg, cpu_access, addr_a_reg)
         && data_hit(data_a_reg, cpu_access.data); // R9 R18
      match_b_next = qual_hit(cfg_b_reg, cpu_access, addr_b_reg); // R18
      // a new hit wins over a clear in the same cycle
      status_next = (status_reg & ~clr_bits)
         | {match_b_next, match_a_next};
      irq_next = |(status_next & irq_en_next);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_a_reg <= '0;
         cfg_b_reg <= '0;
         addr_a_reg <= DCM_ADDR_RST;
         addr_b_reg <= DCM_ADDR_RST;
         data_a_reg <= '0;
         status_reg <= DCM_ST_RST;
         irq_en_reg <= DCM_ST_RST;
         wr_pend_reg <= 1'b0;
         wr_ofs_reg <= DCM_BYTE_RST;
         hrdata_reg <= DCM_WORD_ZERO;
         match_a_reg <= 1'b0;
         match_b_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         cfg_a_reg <= cfg_a_next;
         cfg_b_reg <= cfg_b_next;
         addr_a_reg <= addr_a_next;
         addr_b_reg <= addr_b_next;
         data_a_reg <= data_a_next;
         status_reg <= status_next;
         irq_en_reg <= irq_en_next;
         wr_pend_reg <= wr_pend_next;
         wr_ofs_reg <= wr_ofs_next;
         hrdata_reg <= hrdata_next;
         match_a_reg <= match_a_next;
         match_b_reg <= match_b_next;
         irq_reg <= irq_next;
      end
   end

   // zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = DCM_HRESP_OKAY;
   assign hrdata = hrdata_reg;
   assign match_a = match_a_reg;
   assign match_b = match_b_reg;
   assign irq = irq_reg;

endmodule : dcm_top

// [tb/dcm_top_props.sv]
`timescale 1ns/10ps
module dcm_top_props
   import dcm_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire dcm_access_t cpu_access,
   input wire logic match_a,
   input wire logic match_b,
   input wire logic irq
);
   logic rd_ph, wr_ph, tk;
   assign tk = hsel && hready && htrans == DCM_HTRANS_NONSEQ;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_ph <= 1'b0;
         wr_ph <= 1'b0;
      end else begin
         rd_ph <= tk && !hwrite;
         wr_ph <= tk && hwrite;
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ready_high_a: assert property (hreadyout) else $error("ready low");
   resp_okay_a: assert property (hresp == DCM_HRESP_OKAY)
      else $error("resp not okay");
   rdata_idle_a: assert property (!rd_ph |-> hrdata == 32'h0000_0000)
      else $error("rdata outside read");
   hit_a_cause_a: assert property (match_a |-> $past(cpu_access.valid))
      else $error("match a without access");
   hit_b_cause_a: assert property (match_b |-> $past(cpu_access.valid))
      else $error("match b without access");
   hit_a_pulse_a: assert property (match_a && !cpu_access.valid |=> !match_a)
      else $error("match a too long");
   hit_b_pulse_a: assert property (match_b && !cpu_access.valid |=> !match_b)
      else $error("match b too long");
   irq_rise_a: assert property ($rose(irq) |->
      match_a || match_b || $past(wr_ph) || $past(wr_ph, 2))
      else $error("irq rose without cause");
   irq_fall_a: assert property ($fell(irq) |-> $past(wr_ph) || $past(wr_ph, 2))
      else $error("irq fell without write");
endmodule : dcm_top_props
bind dcm_top dcm_top_props u_props (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .cpu_access(cpu_access), .match_a(match_a), .match_b(match_b), .irq(irq));

// [tb/dcm_cpu_model.sv]
`timescale 1ns/10ps
module dcm_cpu_model
   import dcm_pkg::*;
(
   input wire logic hclk,
   output dcm_access_t cpu_access
);
   initial cpu_access = '0;
   // idle lines carry the inverse so a stale access can never match
   task automatic drive(input dcm_access_t a);
      cpu_access <= a;
      @(posedge hclk);
      cpu_access <= {1'b0, ~a[33:0]};
   endtask : drive
endmodule : dcm_cpu_model

// [tb/testbench.sv]
`timescale 1ns/10ps
module testbench;
   import dcm_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic match_a, match_b, irq;
   logic [31:0] haddr, hwdata, hrdata, r, dw;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [15:0] aa;
   logic [15:0] mk [4] = '{16'h0000, 16'hff00, 16'h00ff, 16'hffff};
   dcm_access_t cpu_access, x;
   dcm_cfg_t ca, cb;
   int miscompares, samples_checked, cyc;
   assign hready = hreadyout;
   dcm_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .cpu_access(cpu_access),
      .match_a(match_a), .match_b(match_b), .irq(irq));
   dcm_cpu_model u_cpu (.hclk(hclk), .cpu_access(cpu_access));
   task automatic summarize;
      $display("checked %0d mismatched %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : summarize
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= DCM_HTRANS_NONSEQ;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : bus
   function automatic logic hit(input dcm_cfg_t c, input logic [15:0] a,
      input dcm_access_t x, input logic [31:0] d, input logic dt);
      logic ok;
      ok = c.enable && x.addr == a;
      if (c.size_qualify_enable && x.is_byte != c.size_select) ok = 0;
      if (c.direction_qualify_enable && x.is_read != c.rw_select) ok = 0;
      if (dt && ((x.data ^ d[15:0]) & d[31:16]) != 0) ok = 0;
      return ok;
   endfunction : hit
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         summarize();
      end
   end
   initial begin
      {hresetn, hsel, hwrite, haddr, hwdata, htrans} = '0;
      hsize = 3'h2;
      {miscompares, samples_checked, cyc} = '0;
      void'($urandom(93));
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int i = 0; i < 8; i++) begin
         bus(1'b0, 8'(4 * i), 32'h0);
         chk(r, 32'h0);
      end
      $display("test reset_values done");
      // -------------------------------------------------------------
      // random qualification, masks cycled through all four patterns
      // -------------------------------------------------------------
      for (int i = 0; i < 300; i++) begin
         ca = 5'($urandom);
         cb = 5'($urandom);
         aa = 16'($urandom);
         dw = {mk[i % 4], 16'($urandom)};
         bus(1'b1, DCM_OFS_CTRL, {19'h0, cb, 3'h0, ca});
         bus(1'b1, DCM_OFS_ADDR_A, {16'h0, aa});
         bus(1'b1, DCM_OFS_ADDR_B, {16'h0, aa});
         bus(1'b1, DCM_OFS_DATA_A, dw);
         bus(1'b0, DCM_OFS_DATA_A, 32'h0);
         chk(r, dw);
         x = {1'b1, aa + 16'($urandom_range(2)) - 16'h1,
            ($urandom_range(1) ? dw[15:0] : 16'($urandom)), 2'($urandom)};
         u_cpu.drive(x);
         @(posedge hclk);
         chk(32'(match_a), 32'(hit(ca, aa, x, dw, 1'b1)));
         chk(32'(match_b), 32'(hit(cb, aa, x, dw, 1'b0)));
      end
      $display("test random_match done");
      bus(1'b1, DCM_OFS_CLEAR, 32'h3);
      bus(1'b1, DCM_OFS_IRQ_EN, 32'h0);
      bus(1'b1, DCM_OFS_CTRL, 32'h1);
      bus(1'b1, DCM_OFS_DATA_A, 32'h0);
      bus(1'b1, DCM_OFS_ADDR_A, 32'h1234);
      bus(1'b0, DCM_OFS_STATUS, 32'h0);
      chk(r, 32'h0);
      u_cpu.drive({1'b1, 16'h1234, 16'h0, 2'h0});
      @(posedge hclk);
      chk(32'(match_a), 32'h1);
      chk(32'(match_b), 32'h0);
      @(posedge hclk);
      chk(32'(match_a), 32'h0);
      bus(1'b0, DCM_OFS_STATUS, 32'h0);
      chk(r, 32'h1);
      chk(32'(irq), 32'h0);
      bus(1'b1, DCM_OFS_IRQ_EN, 32'h1);
      bus(1'b0, DCM_OFS_STATUS, 32'h0);
      chk(32'(irq), 32'h1);
      bus(1'b1, DCM_OFS_CLEAR, 32'h1);
      bus(1'b0, DCM_OFS_STATUS, 32'h0);
      chk(r, 32'h0);
      chk(32'(irq), 32'h0);
      $display("test irq done");
      summarize();
   end
endmodule : testbench
